/* File: hdl/dspctl_pkg.sv */
// package of the serial-input pin and processing-mode control bank
// assumes byte registers on a 32-bit axi4-lite word map, byte address = 4 * index
package dspctl_pkg;

	// register indices; any printed offset is not a multiple of four, so address = 4 * index
	localparam logic [7:0] IDX_RSVD_53        = 8'h35;
	localparam logic [7:0] IDX_PIN_CTRL       = 8'h36;
	localparam logic [7:0] IDX_RSVD_55        = 8'h37;
	localparam logic [7:0] IDX_RSVD_56        = 8'h38;
	localparam logic [7:0] IDX_RSVD_57        = 8'h39;
	localparam logic [7:0] IDX_RSVD_58        = 8'h3a;
	localparam logic [7:0] IDX_ZERO_ONLY      = 8'h3b;
	localparam logic [7:0] IDX_PROC_SEL       = 8'h3c;
	localparam logic [7:0] IDX_DEFAULT_ONLY   = 8'h3d;
	localparam logic [7:0] IDX_ENGINE_MODE    = 8'h3e;
	localparam int         ADDR_W             = 10;

	// reset values
	localparam logic [7:0] RST_RSVD_53        = 8'h09;
	localparam logic [7:0] RST_PIN_CTRL       = 8'h02;
	localparam logic [7:0] RST_RSVD_ZERO      = 8'h00;
	localparam logic [7:0] RST_PROC_SEL       = 8'h01;
	localparam logic [7:0] RST_DEFAULT_ONLY   = 8'h08;
	localparam logic [7:0] RST_ENGINE_MODE    = 8'h00;

	// field positions
	localparam int PIN_MODE_LSB   = 1;
	localparam int PIN_VALUE_BIT  = 0;
	localparam int COND_A_BIT     = 2;
	localparam int COND_B_BIT     = 1;
	localparam int HOLD_CNT_BIT   = 0;

	// serial input pin modes
	typedef enum logic [1:0] {
		PIN_OFF   = 2'b00,
		PIN_AUDIO = 2'b01,
		PIN_GPI   = 2'b10,
		PIN_RSVD  = 2'b11
	} dspctl_pin_e;

	// processing select codes
	localparam logic [4:0] SEL_ENGINE = 5'h00;
	localparam logic [4:0] SEL_P4     = 5'h04;
	localparam logic [4:0] SEL_P6     = 5'h06;
	localparam logic [4:0] SEL_P12    = 5'h0c;
	localparam logic [4:0] SEL_P16    = 5'h10;
	localparam logic [4:0] SEL_P20    = 5'h14;
	localparam logic [4:0] SEL_P22    = 5'h16;
	localparam logic [4:0] SEL_P25    = 5'h19;
	localparam logic [4:0] BLK_NONE   = 5'h00;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : dspctl_pkg

/* File: hdl/dspctl_sync.sv */
// two-flop synchroniser for the serial input pin
// assumes the pin is asynchronous to i_clock
`timescale 1ns/1ps
module dspctl_sync
	import dspctl_pkg::*;
(
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_reset,
	// async level in, synchronised level out
	input  wire logic i_async,
	output logic      o_sync
);
	typedef struct packed {
		logic meta;
		logic sync;
	} dspctl_sync_s;

	dspctl_sync_s state_reg;
	dspctl_sync_s state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.meta = i_async;
		state_next.sync = state_reg.meta;
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sync = state_reg.sync;
endmodule : dspctl_sync

/* File: hdl/dspctl_decode.sv */
// decodes the processing select field into engine choice and block number
// assumes a 5-bit select code held in a register of the same clock
`timescale 1ns/1ps
module dspctl_decode
	import dspctl_pkg::*;
(
	// select code in
	input  wire logic [4:0] i_code,
	// decoded selection
	output logic            o_use_engine,
	output logic [4:0]      o_block,
	output logic            o_illegal
);
	always_comb begin
		o_use_engine = 1'b0;
		o_block      = BLK_NONE;
		o_illegal    = 1'b0;
		if (i_code == SEL_ENGINE) begin
			o_use_engine = 1'b1;
		end else if (i_code >= SEL_P4 && i_code <= SEL_P6) begin
			o_block = i_code;
		end else if (i_code >= SEL_P12 && i_code <= SEL_P16) begin
			o_block = i_code;
		end else if (i_code >= SEL_P20 && i_code <= SEL_P22) begin
			o_block = i_code + 5'h00;
		end else if (i_code == SEL_P25) begin
			o_block = i_code;
		end else begin
			// reserved codes pass no audio; software should not use them
			o_illegal = 1'b1;
		end
	end
endmodule : dspctl_decode

/* File: hdl/dspctl_top.sv */
// Function
// - pin mode 00 powers the serial input buffer down and the pin is ignored.
// - pin mode 01 enables the pin as audio serial input or clock generator source.
// - pin mode 10 makes the pin a general-purpose input; 11 is reserved.
// - select code 0 0000 routes playback through the programmable engine.
// - select codes 0 0100 to 0 0110 choose fixed blocks 4, 5 and 6.
// - select codes 0 1100 to 1 0000 choose fixed blocks 12 to 16.
// - select codes 1 0100 to 1 0110 choose fixed blocks 20 to 22.
// - select code 1 1001 chooses fixed block 25.
// - condition bit A sits at bit 2 of the engine mode register for jumps.
// - condition bit B sits at bit 1 of the engine mode register for jumps.
// - with bit 0 clear the engine instruction counter restarts each frame.
// - with bit 0 set the instruction counter runs on across frames.
//
// control register bank over axi4-lite, byte registers in low lanes of aligned words
// assumes i_pin_async is an asynchronous pin and i_frame_start a same-clock pulse
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dspctl_top
	import dspctl_pkg::*;
(
	// clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_reset,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic [2:0]        i_awprot,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	// axi4-lite write data
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	// axi4-lite write response
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic [2:0]        i_arprot,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	// axi4-lite read data
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	// serial input pin and audio frame timing
	input  wire logic              i_pin_async,
	input  wire logic              i_frame_start,
	// pin control outputs
	output logic                   o_pin_buffer_en,
	output logic                   o_pin_audio_data,
	output logic                   o_pin_to_clock_generator_block,
	output logic                   o_general_purpose_input,
	// processing control outputs
	output logic                   o_use_engine,
	output logic [4:0]             o_fixed_block,
	output logic                   o_select_illegal,
	output logic                   o_conditional_jump_a,
	output logic                   o_conditional_jump_b,
	output logic                   o_counter_restart
);

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [7:0]        rsvd_53;
		logic [7:0]        pin_ctrl;
		logic [7:0]        rsvd_55;
		logic [7:0]        rsvd_56;
		logic [7:0]        rsvd_57;
		logic [7:0]        rsvd_58;
		logic [7:0]        zero_only;
		logic [7:0]        proc_sel;
		logic [7:0]        default_only;
		logic [7:0]        engine_mode;
		logic              aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_held;
		logic [7:0]        w_data;
		logic              w_lane0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              pin_buffer_en;
		logic              pin_audio_data;
		logic              pin_clkgen;
		logic              general_purpose_input;
		logic              use_engine;
		logic [4:0]        fixed_block;
		logic              select_illegal;
		logic              cond_a;
		logic              cond_b;
		logic              counter_restart;
	} dspctl_top_s;

	dspctl_top_s state_reg;
	dspctl_top_s state_next;

	logic       pin_sync;
	logic       dec_engine;
	logic [4:0] dec_block;
	logic       dec_illegal;

	// maps a byte address to its register index, flags unmapped words
	function automatic logic [8:0] dspctl_index(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[ADDR_W-1:2];
		if (addr[1:0] == 2'b00 && idx >= IDX_RSVD_53 && idx <= IDX_ENGINE_MODE) begin
			return {1'b1, idx};
		end
		return {1'b0, idx};
	endfunction : dspctl_index

	////////////////////////////////////////////////////////////////////////////

	dspctl_sync u_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_pin_async),
		.o_sync  (pin_sync)
	);

	dspctl_decode u_decode (
		.i_code       (state_reg.proc_sel[4:0]),
		.o_use_engine (dec_engine),
		.o_block      (dec_block),
		.o_illegal    (dec_illegal)
	);

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [8:0]  widx;
		logic [8:0]  ridx;
		logic [7:0]  rbyte;
		logic [1:0]  pmode;
		logic        pin_val;
		state_next = state_reg;
		widx       = '0;
		ridx       = '0;
		rbyte      = '0;
		pmode      = state_reg.pin_ctrl[PIN_MODE_LSB +: 2];
		pin_val    = 1'b0;

		// capture address and data in either order
		if (i_awvalid && !state_reg.aw_held) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = i_awaddr;
		end
		if (i_wvalid && !state_reg.w_held) begin
			state_next.w_held  = 1'b1;
			state_next.w_data  = i_wdata[7:0];
			state_next.w_lane0 = i_wstrb[0];
		end

		// write commits once both halves are held and no response is pending
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			widx               = dspctl_index(state_reg.aw_addr);
			state_next.aw_held = 1'b0;
			state_next.w_held  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = widx[8] ? RESP_OKAY : RESP_SLVERR;
			if (widx[8] && state_reg.w_lane0) begin
				// reserved registers store what is written; software keeps them at defaults
				unique case (widx[7:0])
					IDX_RSVD_53:      state_next.rsvd_53      = state_reg.w_data;
					IDX_PIN_CTRL:     state_next.pin_ctrl     = state_reg.w_data;
					IDX_RSVD_55:      state_next.rsvd_55      = state_reg.w_data;
					IDX_RSVD_56:      state_next.rsvd_56      = state_reg.w_data;
					IDX_RSVD_57:      state_next.rsvd_57      = state_reg.w_data;
					IDX_RSVD_58:      state_next.rsvd_58      = state_reg.w_data;
					IDX_ZERO_ONLY:    state_next.zero_only    = state_reg.w_data;
					IDX_PROC_SEL:     state_next.proc_sel     = state_reg.w_data;
					IDX_DEFAULT_ONLY: state_next.default_only = state_reg.w_data;
					IDX_ENGINE_MODE:  state_next.engine_mode  = state_reg.w_data;
					default:          state_next.engine_mode  = state_reg.engine_mode;
				endcase
			end
		end
		if (state_reg.bvalid && i_bready) begin
			state_next.bvalid = 1'b0;
		end

		// read: one word at a time, answered the cycle after arvalid is taken
		if (i_arvalid && !state_reg.rvalid) begin
			ridx = dspctl_index(i_araddr);
			unique case (ridx[7:0])
				IDX_RSVD_53:      rbyte = state_reg.rsvd_53;
				IDX_PIN_CTRL:     rbyte = {state_reg.pin_ctrl[7:1], state_reg.general_purpose_input};
				IDX_RSVD_55:      rbyte = state_reg.rsvd_55;
				IDX_RSVD_56:      rbyte = state_reg.rsvd_56;
				IDX_RSVD_57:      rbyte = state_reg.rsvd_57;
				IDX_RSVD_58:      rbyte = state_reg.rsvd_58;
				IDX_ZERO_ONLY:    rbyte = state_reg.zero_only;
				IDX_PROC_SEL:     rbyte = state_reg.proc_sel;
				IDX_DEFAULT_ONLY: rbyte = state_reg.default_only;
				IDX_ENGINE_MODE:  rbyte = state_reg.engine_mode;
				default:          rbyte = 8'h00;
			endcase
			state_next.rvalid = 1'b1;
			state_next.rdata  = {24'h000000, ridx[8] ? rbyte : 8'h00};
			state_next.rresp  = ridx[8] ? RESP_OKAY : RESP_SLVERR;
		end else if (state_reg.rvalid && i_rready) begin
			state_next.rvalid = 1'b0;
		end

		// pin mode steering; the off mode gates the buffer so the pin reads as zero
		pin_val = pin_sync;
		state_next.pin_buffer_en  = (pmode == PIN_AUDIO) || (pmode == PIN_GPI);
		state_next.pin_audio_data = (pmode == PIN_AUDIO) && pin_val;
		state_next.pin_clkgen     = (pmode == PIN_AUDIO) && pin_val;
		state_next.general_purpose_input            = (pmode == PIN_GPI) && pin_val;

		// processing selection
		state_next.use_engine     = dec_engine;
		state_next.fixed_block    = dec_block;
		state_next.select_illegal = dec_illegal;

		// engine control bits
		state_next.cond_a = state_reg.engine_mode[COND_A_BIT];
		state_next.cond_b = state_reg.engine_mode[COND_B_BIT];
		// restart pulse follows the frame start only while the hold bit is clear
		state_next.counter_restart = i_frame_start &&
			!state_reg.engine_mode[HOLD_CNT_BIT];
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state_reg              <= '0;
			state_reg.rsvd_53      <= RST_RSVD_53;
			state_reg.pin_ctrl     <= RST_PIN_CTRL;
			state_reg.rsvd_55      <= RST_RSVD_ZERO;
			state_reg.rsvd_56      <= RST_RSVD_ZERO;
			state_reg.rsvd_57      <= RST_RSVD_ZERO;
			state_reg.rsvd_58      <= RST_RSVD_ZERO;
			state_reg.zero_only    <= RST_RSVD_ZERO;
			state_reg.proc_sel     <= RST_PROC_SEL;
			state_reg.default_only <= RST_DEFAULT_ONLY;
			state_reg.engine_mode  <= RST_ENGINE_MODE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	assign o_awready = !state_reg.aw_held;
	assign o_wready  = !state_reg.w_held;
	assign o_bresp   = state_reg.bresp;
	assign o_bvalid  = state_reg.bvalid;
	assign o_arready = !state_reg.rvalid;
	assign o_rdata   = state_reg.rdata;
	assign o_rresp   = state_reg.rresp;
	assign o_rvalid  = state_reg.rvalid;

	assign o_pin_buffer_en                = state_reg.pin_buffer_en;
	assign o_pin_audio_data               = state_reg.pin_audio_data;
	assign o_pin_to_clock_generator_block = state_reg.pin_clkgen;
	assign o_general_purpose_input        = state_reg.general_purpose_input;
	assign o_use_engine                   = state_reg.use_engine;
	assign o_fixed_block                  = state_reg.fixed_block;
	assign o_select_illegal               = state_reg.select_illegal;
	assign o_conditional_jump_a           = state_reg.cond_a;
	assign o_conditional_jump_b           = state_reg.cond_b;
	assign o_counter_restart              = state_reg.counter_restart;

endmodule : dspctl_top

/* File: verification/dspctl_top_monitor.sv */
// port checker of the pin and processing control bank
// assumes it is bound into dspctl_top and sees only that module's ports
`timescale 1ns/1ps
module dspctl_top_monitor (
	// clock and reset
	input wire logic       i_clock,
	input wire logic       i_reset,
	// register bus
	input wire logic       i_awvalid,
	input wire logic       o_awready,
	input wire logic       i_wvalid,
	input wire logic       o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic       o_bvalid,
	input wire logic       i_bready,
	input wire logic       i_arvalid,
	input wire logic       o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic       o_rvalid,
	input wire logic       i_rready,
	// pin and processing outputs
	input wire logic       i_frame_start,
	input wire logic       o_pin_buffer_en,
	input wire logic       o_pin_audio_data,
	input wire logic       o_pin_to_clock_generator_block,
	input wire logic       o_general_purpose_input,
	input wire logic       o_use_engine,
	input wire logic [4:0] o_fixed_block,
	input wire logic       o_select_illegal,
	input wire logic       o_counter_restart
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	////////////////////////////////////////////////////////////////////////////////
	a_pin_off_quiet: assert property (!o_pin_buffer_en |-> !o_pin_audio_data && !o_general_purpose_input)
		else $error("pin outputs active with buffer off");
	a_clkgen_follow: assert property (o_pin_audio_data == o_pin_to_clock_generator_block)
		else $error("clock source differs from audio data");
	a_gpi_exclusive: assert property (o_general_purpose_input |-> o_pin_buffer_en && !o_pin_audio_data)
		else $error("gpi active together with audio path");
	a_engine_exclusive: assert property (o_use_engine |-> o_fixed_block == 5'h00 && !o_select_illegal)
		else $error("engine and fixed block both selected");
	a_block_legal: assert property (o_fixed_block != 5'h00 |->
		o_fixed_block inside {[5'h04:5'h06], [5'h0c:5'h10], [5'h14:5'h16], 5'h19} && !o_use_engine)
		else $error("fixed block number not a legal code");
	a_restart_cause: assert property (o_counter_restart |-> $past(i_frame_start))
		else $error("counter restart without frame start");
	// the bus relations below guard the access path every register rule relies on
	a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write response late");
	a_resp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read answer late");
	a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data not held");
endmodule : dspctl_top_monitor

bind dspctl_top dspctl_top_monitor i_dspctl_top_monitor (.*);

/* File: verification/tb_top.sv */
// self-checking bench of the pin and processing control bank
// assumes an axi4-lite master driven here and a 250 MHz clock
`timescale 1ns/1ps
module tb_top
	import dspctl_pkg::*;
;
	logic              i_clock = 1'h0;
	logic              i_reset;
	logic [ADDR_W-1:0] i_awaddr, i_araddr;
	logic [2:0]        i_awprot, i_arprot;
	logic              i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [31:0]       i_wdata, o_rdata;
	logic [3:0]        i_wstrb;
	logic [1:0]        o_bresp, o_rresp;
	logic              i_pin_async, i_frame_start;
	logic              o_pin_buffer_en, o_pin_audio_data, o_pin_to_clock_generator_block;
	logic              o_general_purpose_input, o_use_engine, o_select_illegal;
	logic              o_conditional_jump_a, o_conditional_jump_b, o_counter_restart;
	logic [4:0]        o_fixed_block;
	int                failures = 0;
	int                tests_run = 0;

	dspctl_top i_dspctl_top (.*);

	always #2 i_clock = ~i_clock;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [9:0] ba(input logic [7:0] idx);
		return {idx, 2'h0};
	endfunction : ba

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic axi_write(input logic [9:0] a, input logic [7:0] d, input logic s,
		input logic [1:0] er);
		i_awaddr <= a;
		i_wdata <= {24'h0, d};
		i_wstrb <= {3'h0, s};
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		// the valids set above land only at the end of this step, so test after the edge
		do begin
			@(posedge i_clock);
			if (i_awvalid && o_awready) i_awvalid <= 1'h0;
			if (i_wvalid && o_wready) i_wvalid <= 1'h0;
		end while ((i_awvalid && !o_awready) || (i_wvalid && !o_wready));
		// late bready lets the response wait on the bus for a while
		repeat (2) @(posedge i_clock);
		i_bready <= 1'h1;
		do @(posedge i_clock); while (!o_bvalid);
		check(o_bresp, er, "write response");
		i_bready <= 1'h0;
	endtask : axi_write

	task automatic axi_read(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		do @(posedge i_clock); while (!o_arready);
		i_arvalid <= 1'h0;
		@(posedge i_clock);
		i_rready <= 1'h1;
		do @(posedge i_clock); while (!o_rvalid);
		check(o_rdata, ed, "read data");
		check(o_rresp, er, "read response");
		i_rready <= 1'h0;
	endtask : axi_read

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		logic [7:0] rst [10];
		rst = '{8'h09, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00};
		check(o_select_illegal, 1'h1, "reset code reserved");
		for (int k = 0; k < 10; k++) axi_read(ba(8'(8'h35 + k)), {24'h0, rst[k]}, RESP_OKAY);
		$display("reset values done");
	endtask : t_reset_values

	task automatic t_pin_modes;
		logic [1:0] m;
		for (int k = 0; k < 4; k++) begin
			m = 2'(k);
			axi_write(ba(IDX_PIN_CTRL), {5'h00, m, 1'h0}, 1'h1, RESP_OKAY);
			for (int v = 0; v < 2; v++) begin
				i_pin_async <= v[0];
				repeat (5) @(posedge i_clock);
				check(o_pin_buffer_en, m == 2'h1 || m == 2'h2, "buffer enable");
				check(o_pin_audio_data, m == 2'h1 && v[0], "audio data");
				check(o_pin_to_clock_generator_block, m == 2'h1 && v[0], "clock src");
				check(o_general_purpose_input, m == 2'h2 && v[0], "gpi");
				axi_read(ba(IDX_PIN_CTRL), {29'h0, m, m == 2'h2 && v[0]}, RESP_OKAY);
			end
		end
		$display("pin modes done");
	endtask : t_pin_modes

	task automatic t_select_codes;
		logic [4:0] c;
		logic       legal;
		for (int k = 0; k < 32; k++) begin
			c = 5'(k);
			legal = c inside {[5'h04:5'h06], [5'h0c:5'h10], [5'h14:5'h16], 5'h19};
			axi_write(ba(IDX_PROC_SEL), {3'h0, c}, 1'h1, RESP_OKAY);
			repeat (2) @(posedge i_clock);
			check(o_use_engine, c == 5'h00, "engine select");
			check(o_fixed_block, legal ? c : 5'h00, "fixed block");
			check(o_select_illegal, !legal && c != 5'h00, "reserved code");
		end
		axi_read(ba(IDX_PROC_SEL), 32'h1f, RESP_OKAY);
		$display("select codes done");
	endtask : t_select_codes

	task automatic frame_pulse(input logic exp);
		@(posedge i_clock);
		i_frame_start <= 1'h1;
		@(posedge i_clock);
		i_frame_start <= 1'h0;
		@(posedge i_clock);
		check(o_counter_restart, exp, "counter restart");
		@(posedge i_clock);
		check(o_counter_restart, 1'h0, "restart width");
	endtask : frame_pulse

	task automatic t_engine_mode;
		axi_write(ba(IDX_ENGINE_MODE), 8'h04, 1'h1, RESP_OKAY);
		repeat (2) @(posedge i_clock);
		check(o_conditional_jump_a, 1'h1, "bit a set");
		check(o_conditional_jump_b, 1'h0, "bit b clear");
		frame_pulse(1'h1);
		axi_write(ba(IDX_ENGINE_MODE), 8'h03, 1'h1, RESP_OKAY);
		repeat (2) @(posedge i_clock);
		check(o_conditional_jump_a, 1'h0, "bit a clear");
		check(o_conditional_jump_b, 1'h1, "bit b set");
		frame_pulse(1'h0);
		$display("engine mode done");
	endtask : t_engine_mode

	task automatic t_bus_errors;
		axi_write(10'h0fc, 8'h5a, 1'h1, RESP_SLVERR);
		axi_read(10'h0fc, 32'h0, RESP_SLVERR);
		axi_read(10'h0d5, 32'h0, RESP_SLVERR);
		// a cleared strobe must leave the byte untouched yet answer okay
		axi_write(ba(IDX_RSVD_56), 8'ha5, 1'h0, RESP_OKAY);
		axi_read(ba(IDX_RSVD_56), 32'h0, RESP_OKAY);
		axi_write(ba(IDX_RSVD_56), 8'ha5, 1'h1, RESP_OKAY);
		axi_read(ba(IDX_RSVD_56), 32'ha5, RESP_OKAY);
		$display("bus errors done");
	endtask : t_bus_errors

	task automatic results;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_reset, i_awaddr, i_araddr, i_awprot, i_arprot} = {1'h1, 26'h0};
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		{i_wdata, i_wstrb, i_pin_async, i_frame_start} = 38'h0;
		repeat (20) @(posedge i_clock);
		i_reset <= 1'h0;
		repeat (2) @(posedge i_clock);
		t_reset_values();
		t_pin_modes();
		t_select_codes();
		t_engine_mode();
		t_bus_errors();
		results();
	end

	// whole run is a few hundred cycles; this 25000-cycle limit is over fifty times that
	initial begin
		#100000;
		failures++;
		results();
	end
endmodule : tb_top
